//--- core/isr_pkg.sv
// Constants, bit maps and command codes of the instrument status bank
package isr_pkg;

	// ==========================================================
	// Widths
	// ==========================================================
	localparam int ISR_W = 16;              // Width of each status group
	localparam int ISR_CNT_W = 16;          // Width of the reading count

	// ==========================================================
	// Host command codes
	// ==========================================================
	typedef enum logic [2:0] {
		ISR_OP_RD_COND = 3'h0,          // Read condition view
		ISR_OP_RD_EVT = 3'h1,           // Read event view, then clear it
		ISR_OP_RD_EN = 3'h2,            // Read enable mask
		ISR_OP_WR_EN = 3'h3,            // Write enable mask
		ISR_OP_CLS = 3'h4,              // Clear all event registers
		ISR_OP_WR_THR = 3'h5,           // Write reading-count threshold
		ISR_OP_RD_THR = 3'h6,           // Read reading-count threshold
		ISR_OP_NOP = 3'h7               // No operation
	} isr_op_t;

	// ==========================================================
	// Group selectors
	// ==========================================================
	localparam logic [1:0] ISR_GRP_MFLT = 2'h0;   // Measurement fault
	localparam logic [1:0] ISR_GRP_OPST = 2'h1;   // Operation state
	localparam logic [1:0] ISR_GRP_ALRM = 2'h2;   // Alarm state

	// ==========================================================
	// Measurement fault bit positions
	// ==========================================================
	localparam int MFLT_VOLT = 0;           // Voltage overload
	localparam int MFLT_CURR = 1;           // Current overload
	localparam int MFLT_FREQ = 5;           // Frequency overload or timeout
	localparam int MFLT_CAP = 7;            // Capacitance overload
	localparam int MFLT_CAL = 8;            // Calibration constant corrupt
	localparam int MFLT_RES = 9;            // Resistance overload
	localparam int MFLT_TEMP = 10;          // Temperature overload
	localparam int MFLT_LOLIM = 11;         // Lower limit test failed
	localparam int MFLT_MEMOVF = 12;        // Reading storage overflow

	// ==========================================================
	// Operation state bit positions
	// ==========================================================
	localparam int OPST_CAL = 0;            // Calibrating
	localparam int OPST_TEST = 1;           // Self-test running
	localparam int OPST_SCAN = 4;           // Scanning
	localparam int OPST_WTRIG = 5;          // Waiting for trigger
	localparam int OPST_USB = 7;            // USB drive detected
	localparam int OPST_FPCHG = 8;          // Front panel config change
	localparam int OPST_THR = 9;            // Reading count over threshold
	localparam int OPST_LOCK = 10;          // Instrument locked
	localparam int OPST_SETCHG = 11;        // Settings changed event
	localparam int OPST_GERR = 13;          // Global error queue not empty

	// ==========================================================
	// Alarm state bit positions
	// ==========================================================
	localparam int ALRM_EVT0 = 0;           // Alarm 1..4 events at 0..3
	localparam int ALRM_QNE = 4;            // Alarm queue not empty
	localparam int ALRM_QOVF = 5;           // Alarm queue overflow
	localparam int ALRM_ACT0 = 6;           // Alarm 1..4 active at 6..9
	localparam int ALRM_LOLIM = 12;         // Lower limit alarm
	localparam int ALRM_UPLIM = 13;         // Upper limit alarm

	// ==========================================================
	// Implemented, event-only and overload masks
	// ==========================================================
	localparam logic [ISR_W-1:0] MFLT_IMPL = 16'h1FA3;
	localparam logic [ISR_W-1:0] MFLT_EVO = 16'h06A3;
	localparam logic [ISR_W-1:0] MFLT_OVL = 16'h06A3;
	localparam logic [ISR_W-1:0] OPST_IMPL = 16'h2FB3;
	localparam logic [ISR_W-1:0] OPST_EVO = 16'h0800;
	localparam logic [ISR_W-1:0] ALRM_IMPL = 16'h33FF;
	localparam logic [ISR_W-1:0] ALRM_EVO = 16'h302F;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [ISR_W-1:0] ISR_EVT_RST = 16'h0000;
	localparam logic [ISR_W-1:0] ISR_EN_RST = 16'h0000;
	localparam logic [ISR_W-1:0] ISR_ARM_RST = 16'h0000;
	localparam logic [ISR_CNT_W-1:0] ISR_THR_RST = 16'h0000;

endpackage : isr_pkg

//--- core/isr_group.sv
// One status group: condition view, event latch, enable mask, summary
`timescale 1ns/1ps

module isr_group
	import isr_pkg::*;
#(
	parameter logic [ISR_W-1:0] IMPL = 16'hFFFF,  // Implemented bits
	parameter logic [ISR_W-1:0] EVO = 16'h0000    // Event-only bits
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [ISR_W-1:0] cond_live,
	input wire logic [ISR_W-1:0] evt_set,
	input wire logic evt_clr,
	input wire logic en_we,
	input wire logic [ISR_W-1:0] en_wdata,
	output logic [ISR_W-1:0] cond_val,
	output logic [ISR_W-1:0] event_val,
	output logic [ISR_W-1:0] enable_val,
	output logic summary
);

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		logic [ISR_W-1:0] evt;          // Latched events
		logic [ISR_W-1:0] en;           // Enable mask
		logic [ISR_W-1:0] prev;         // Condition of last cycle
	} isr_grp_st_t;

	isr_grp_st_t st_r;                      // Registered state
	isr_grp_st_t st_nxt;                    // Next state
	logic [ISR_W-1:0] rise;                 // Condition rising edges

	// Live condition, event-only and reserved bits forced low
	assign cond_val = cond_live & IMPL & ~EVO;
	assign event_val = st_r.evt;
	assign enable_val = st_r.en;
	assign summary = |(st_r.evt & st_r.en);
	assign rise = cond_val & ~st_r.prev;

	// Next-state logic
	always_comb begin
		st_nxt = st_r;
		st_nxt.prev = cond_val;
		// Clear first, new sets win over the clear
		if (evt_clr) begin
			st_nxt.evt = ISR_EVT_RST;
		end
		st_nxt.evt = st_nxt.evt | (((evt_set & EVO) | rise) & IMPL);
		// Only implemented bits take an enable
		if (en_we) begin
			st_nxt.en = en_wdata & IMPL;
		end
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st_r.evt <= ISR_EVT_RST;
			st_r.en <= ISR_EN_RST;
			st_r.prev <= ISR_EVT_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule : isr_group

//--- core/isr_status_bank.sv
// Instrument status bank: three status groups behind a host command port
`timescale 1ns/1ps

module isr_status_bank
	import isr_pkg::*;
#(
	parameter int CNT_W = ISR_CNT_W         // Reading count width
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	// Measurement engine
	input wire logic meas_start,
	input wire logic ovl_volt,
	input wire logic ovl_curr,
	input wire logic ovl_freq,
	input wire logic ovl_cap,
	input wire logic ovl_res,
	input wire logic ovl_temp,
	input wire logic cal_corrupt,
	input wire logic lo_limit_fail,
	input wire logic mem_overflow,
	// Instrument state
	input wire logic cal_busy,
	input wire logic selftest_busy,
	input wire logic scan_busy,
	input wire logic wait_trig,
	input wire logic usb_drive,
	input wire logic inst_locked,
	input wire logic err_queue_ne,
	input wire logic [CNT_W-1:0] rd_count,
	input wire logic cfg_front_chg,
	input wire logic cfg_remote_chg,
	// Alarm engine
	input wire logic [3:0] alarm_event,
	input wire logic alarm_qne,
	input wire logic alarm_qovf,
	input wire logic [3:0] alarm_active,
	input wire logic alarm_lo,
	input wire logic alarm_up,
	// Host command port
	input wire logic host_req,
	input wire logic [2:0] host_op,
	input wire logic [1:0] host_grp,
	input wire logic [ISR_W-1:0] host_wdata,
	output logic host_ack,
	output logic [ISR_W-1:0] host_rdata,
	// Summary bits toward the status byte
	output logic sum_mflt,
	output logic sum_opst,
	output logic sum_alrm
);

	// ==========================================================
	// State of the bank
	// ==========================================================
	typedef struct packed {
		logic [ISR_W-1:0] arm;          // Overload bits still allowed
		logic fp_chg;                   // Front panel change since start
		logic [CNT_W-1:0] thr;          // Reading-count threshold
		logic ack;                      // Host answer strobe
		logic [ISR_W-1:0] rdata;        // Host answer data
		logic s_mflt;                   // Fault group summary
		logic s_opst;                   // Operation group summary
		logic s_alrm;                   // Alarm group summary
	} isr_bank_st_t;

	isr_bank_st_t st_r;                     // Registered state
	isr_bank_st_t st_nxt;                   // Next state

	// ==========================================================
	// Internal nets
	// ==========================================================
	isr_op_t op;                            // Decoded host command
	logic cmd_rd_cond;                      // Condition read taken
	logic cmd_rd_evt;                       // Event read taken
	logic cmd_rd_en;                        // Enable read taken
	logic cmd_wr_en;                        // Enable write taken
	logic cmd_cls;                          // Clear status taken
	logic cmd_wr_thr;                       // Threshold write taken
	logic cmd_rd_thr;                       // Threshold read taken
	logic [2:0] grp_sel;                    // One-hot group select
	logic [ISR_W-1:0] ovl_vec;              // Raw overload pulses
	logic [ISR_W-1:0] ovl_take;             // Overloads allowed through
	logic [ISR_W-1:0] mflt_cond;            // Fault live conditions
	logic [ISR_W-1:0] mflt_set;             // Fault event pulses
	logic [ISR_W-1:0] opst_cond;            // Operation live conditions
	logic [ISR_W-1:0] opst_set;             // Operation event pulses
	logic [ISR_W-1:0] alrm_cond;            // Alarm live conditions
	logic [ISR_W-1:0] alrm_set;             // Alarm event pulses
	logic [2:0] evt_clr;                    // Per-group event clear
	logic [2:0] en_we;                      // Per-group enable write
	logic [ISR_W-1:0] cond_v [3];           // Group condition views
	logic [ISR_W-1:0] event_v [3];          // Group event views
	logic [ISR_W-1:0] enable_v [3];         // Group enable views
	logic [2:0] summ;                       // Group summaries

	// ==========================================================
	// Command decode
	// ==========================================================
	assign op = isr_op_t'(host_op);
	assign cmd_rd_cond = host_req && (op == ISR_OP_RD_COND);
	assign cmd_rd_evt = host_req && (op == ISR_OP_RD_EVT);
	assign cmd_rd_en = host_req && (op == ISR_OP_RD_EN);
	assign cmd_wr_en = host_req && (op == ISR_OP_WR_EN);
	assign cmd_cls = host_req && (op == ISR_OP_CLS);
	assign cmd_wr_thr = host_req && (op == ISR_OP_WR_THR);
	assign cmd_rd_thr = host_req && (op == ISR_OP_RD_THR);

	// Group select, selector 3 reaches no group
	always_comb begin
		grp_sel = 3'h0;
		case (host_grp)
			ISR_GRP_MFLT: begin
				grp_sel = 3'h1;
			end
			ISR_GRP_OPST: begin
				grp_sel = 3'h2;
			end
			ISR_GRP_ALRM: begin
				grp_sel = 3'h4;
			end
			default: begin
				grp_sel = 3'h0;
			end
		endcase
	end

	// Reading an event view or clear-status empties events
	assign evt_clr = ({3{cmd_rd_evt}} & grp_sel) | {3{cmd_cls}};
	assign en_we = {3{cmd_wr_en}} & grp_sel;

	// ==========================================================
	// Measurement fault sources
	// ==========================================================
	// Overload pulses gathered at their bit places
	always_comb begin
		ovl_vec = ISR_EVT_RST;
		ovl_vec[MFLT_VOLT] = ovl_volt;
		ovl_vec[MFLT_CURR] = ovl_curr;
		ovl_vec[MFLT_FREQ] = ovl_freq;
		ovl_vec[MFLT_CAP] = ovl_cap;
		ovl_vec[MFLT_RES] = ovl_res;
		ovl_vec[MFLT_TEMP] = ovl_temp;
	end

	// An overload passes only while its arm bit stands
	assign ovl_take = ovl_vec & st_r.arm & MFLT_OVL;

	// Level conditions of the fault group
	always_comb begin
		mflt_cond = ISR_EVT_RST;
		mflt_cond[MFLT_CAL] = cal_corrupt;
		mflt_cond[MFLT_LOLIM] = lo_limit_fail;
		mflt_cond[MFLT_MEMOVF] = mem_overflow;
	end
	assign mflt_set = ovl_take;

	// ==========================================================
	// Operation state sources
	// ==========================================================
	always_comb begin
		opst_cond = ISR_EVT_RST;
		opst_set = ISR_EVT_RST;
		opst_cond[OPST_CAL] = cal_busy;
		opst_cond[OPST_TEST] = selftest_busy;
		opst_cond[OPST_SCAN] = scan_busy;
		opst_cond[OPST_WTRIG] = wait_trig;
		opst_cond[OPST_USB] = usb_drive;
		opst_cond[OPST_FPCHG] = st_r.fp_chg;
		opst_cond[OPST_THR] = (rd_count > st_r.thr);
		opst_cond[OPST_LOCK] = inst_locked;
		opst_cond[OPST_GERR] = err_queue_ne;
		// Any change, either source, is a latched event
		opst_set[OPST_SETCHG] = cfg_front_chg | cfg_remote_chg;
	end

	// ==========================================================
	// Alarm state sources
	// ==========================================================
	always_comb begin
		alrm_cond = ISR_EVT_RST;
		alrm_set = ISR_EVT_RST;
		alrm_set[ALRM_EVT0 +: 4] = alarm_event;
		alrm_cond[ALRM_QNE] = alarm_qne;
		alrm_set[ALRM_QOVF] = alarm_qovf;
		alrm_cond[ALRM_ACT0 +: 4] = alarm_active;
		alrm_set[ALRM_LOLIM] = alarm_lo;
		alrm_set[ALRM_UPLIM] = alarm_up;
	end

	// ==========================================================
	// The three groups
	// ==========================================================
	// Measurement fault group
	isr_group #(
		.IMPL(MFLT_IMPL),
		.EVO(MFLT_EVO)
	) u_grp_mflt (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.cond_live(mflt_cond),
		.evt_set(mflt_set),
		.evt_clr(evt_clr[0]),
		.en_we(en_we[0]),
		.en_wdata(host_wdata),
		.cond_val(cond_v[0]),
		.event_val(event_v[0]),
		.enable_val(enable_v[0]),
		.summary(summ[0])
	);

	// Operation state group
	isr_group #(
		.IMPL(OPST_IMPL),
		.EVO(OPST_EVO)
	) u_grp_opst (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.cond_live(opst_cond),
		.evt_set(opst_set),
		.evt_clr(evt_clr[1]),
		.en_we(en_we[1]),
		.en_wdata(host_wdata),
		.cond_val(cond_v[1]),
		.event_val(event_v[1]),
		.enable_val(enable_v[1]),
		.summary(summ[1])
	);

	// Alarm state group
	isr_group #(
		.IMPL(ALRM_IMPL),
		.EVO(ALRM_EVO)
	) u_grp_alrm (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.cond_live(alrm_cond),
		.evt_set(alrm_set),
		.evt_clr(evt_clr[2]),
		.en_we(en_we[2]),
		.en_wdata(host_wdata),
		.cond_val(cond_v[2]),
		.event_val(event_v[2]),
		.enable_val(enable_v[2]),
		.summary(summ[2])
	);

	// ==========================================================
	// Next-state logic of the bank
	// ==========================================================
	always_comb begin
		st_nxt = st_r;
		// Spent overloads lose their arm bit
		st_nxt.arm = st_r.arm & ~ovl_take;
		// A start re-arms every overload bit
		if (meas_start) begin
			st_nxt.arm = MFLT_OVL;
		end
		// Start clears the front panel flag, a change sets it
		st_nxt.fp_chg = (st_r.fp_chg & ~meas_start) | cfg_front_chg;
		// Threshold written by the host
		if (cmd_wr_thr) begin
			st_nxt.thr = host_wdata[CNT_W-1:0];
		end
		// Answer strobe for every request
		st_nxt.ack = host_req;
		// Answer data, held until the next request
		if (host_req) begin
			st_nxt.rdata = ISR_EVT_RST;
			if (cmd_rd_thr) begin
				st_nxt.rdata[CNT_W-1:0] = st_r.thr;
			end
			for (int g = 0; g < 3; g++) begin
				if (grp_sel[g]) begin
					// Condition read leaves everything intact
					if (cmd_rd_cond) begin
						st_nxt.rdata = cond_v[g];
					end
					// Event read returns events held before the clear
					if (cmd_rd_evt) begin
						st_nxt.rdata = event_v[g];
					end
					if (cmd_rd_en) begin
						st_nxt.rdata = enable_v[g];
					end
				end
			end
		end
		// Summaries registered toward the status byte
		st_nxt.s_mflt = summ[0];
		st_nxt.s_opst = summ[1];
		st_nxt.s_alrm = summ[2];
	end

	// ==========================================================
	// State register
	// ==========================================================
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st_r.arm <= ISR_ARM_RST;
			st_r.fp_chg <= 1'b0;
			st_r.thr <= CNT_W'(ISR_THR_RST);
			st_r.ack <= 1'b0;
			st_r.rdata <= ISR_EVT_RST;
			st_r.s_mflt <= 1'b0;
			st_r.s_opst <= 1'b0;
			st_r.s_alrm <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs, straight from the state register
	// ==========================================================
	assign host_ack = st_r.ack;
	assign host_rdata = st_r.rdata;
	assign sum_mflt = st_r.s_mflt;
	assign sum_opst = st_r.s_opst;
	assign sum_alrm = st_r.s_alrm;

endmodule : isr_status_bank

//--- verif/isr_status_bank_checker.sv
// Port-level checker of the instrument status bank
`timescale 1ns/1ps

module isr_status_bank_checker
	import isr_pkg::*;
#(
	parameter int CNT_W = ISR_CNT_W // Reading count width
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic cal_corrupt,
	input wire logic lo_limit_fail,
	input wire logic mem_overflow,
	input wire logic cal_busy,
	input wire logic selftest_busy,
	input wire logic scan_busy,
	input wire logic wait_trig,
	input wire logic usb_drive,
	input wire logic inst_locked,
	input wire logic err_queue_ne,
	input wire logic [3:0] alarm_active,
	input wire logic alarm_qne,
	input wire logic host_req,
	input wire logic [2:0] host_op,
	input wire logic [1:0] host_grp,
	input wire logic [ISR_W-1:0] host_wdata,
	input wire logic host_ack,
	input wire logic [ISR_W-1:0] host_rdata,
	input wire logic sum_mflt
);
	// ==========================================================
	// Clock, reset and request decode
	// ==========================================================
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	wire logic rd_any = host_req && (host_op <= ISR_OP_RD_EN); // Any group view read
	wire logic rd_cnd = host_req && (host_op == ISR_OP_RD_COND); // Live view

	// ==========================================================
	// Assertions
	// ==========================================================
	AST_ACK: assert property (host_req |=> host_ack)
		else $error("Request not answered");
	AST_COND_MFLT: assert property (rd_cnd && host_grp == ISR_GRP_MFLT
		|=> host_rdata == {3'h0, $past(mem_overflow), $past(lo_limit_fail),
		2'h0, $past(cal_corrupt), 8'h00})
		else $error("Fault condition view wrong");
	AST_COND_OPST: assert property (rd_cnd && host_grp == ISR_GRP_OPST
		|=> (host_rdata & 16'hFCFF) == {2'h0, $past(err_queue_ne), 2'h0,
		$past(inst_locked), 2'h0, $past(usb_drive), 1'b0, $past(wait_trig),
		$past(scan_busy), 2'h0, $past(selftest_busy), $past(cal_busy)})
		else $error("Operation condition view wrong");
	AST_COND_ALRM: assert property (rd_cnd && host_grp == ISR_GRP_ALRM
		|=> host_rdata == {6'h00, $past(alarm_active), 1'b0, $past(alarm_qne), 4'h0})
		else $error("Alarm condition view wrong");
	AST_RSV_MFLT: assert property (rd_any && host_grp == ISR_GRP_MFLT
		|=> (host_rdata & ~MFLT_IMPL) == 16'h0000)
		else $error("Fault reserved bit set");
	AST_RSV_OPST: assert property (rd_any && host_grp == ISR_GRP_OPST
		|=> (host_rdata & ~OPST_IMPL) == 16'h0000)
		else $error("Operation reserved bit set");
	AST_RSV_ALRM: assert property (rd_any && host_grp == ISR_GRP_ALRM
		|=> (host_rdata & ~ALRM_IMPL) == 16'h0000)
		else $error("Alarm reserved bit set");
	AST_GRP_NONE: assert property (rd_any && host_grp == 2'h3 |=>
		host_rdata == 16'h0000)
		else $error("Unused group read not zero");
	AST_SUM_OFF: assert property (host_req && host_op == ISR_OP_WR_EN &&
		host_grp == ISR_GRP_MFLT && host_wdata == 16'h0000 |-> ##3 !sum_mflt)
		else $error("Summary high with mask cleared");

	// ==========================================================
	// Coverage of the main scenarios
	// ==========================================================
	COV_SUM: cover property (sum_mflt);
	COV_DATA: cover property (host_ack && host_rdata != 16'h0000);
	COV_CLS: cover property (host_req && host_op == ISR_OP_CLS);
endmodule : isr_status_bank_checker

bind isr_status_bank isr_status_bank_checker #(.CNT_W(CNT_W)) u_chk (
	.clk_sys(clk_sys), .rst_b(rst_b), .cal_corrupt(cal_corrupt),
	.lo_limit_fail(lo_limit_fail), .mem_overflow(mem_overflow),
	.cal_busy(cal_busy), .selftest_busy(selftest_busy),
	.scan_busy(scan_busy), .wait_trig(wait_trig), .usb_drive(usb_drive),
	.inst_locked(inst_locked), .err_queue_ne(err_queue_ne),
	.alarm_active(alarm_active), .alarm_qne(alarm_qne),
	.host_req(host_req), .host_op(host_op), .host_grp(host_grp),
	.host_wdata(host_wdata), .host_ack(host_ack),
	.host_rdata(host_rdata), .sum_mflt(sum_mflt));

//--- verif/isr_host_model.sv
// Remote host model issuing status commands
`timescale 1ns/1ps

module isr_host_model
	import isr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [ISR_W-1:0] host_rdata,
	output logic host_req,
	output logic [2:0] host_op,
	output logic [1:0] host_grp,
	output logic [ISR_W-1:0] host_wdata
);
	// Idle command port at time zero
	initial begin
		host_req = 1'b0;
		host_op = ISR_OP_NOP;
		host_grp = 2'h3;
		host_wdata = 16'h0000;
	end

	// One request cycle, answer taken one cycle later
	task automatic cmd(input logic [2:0] op, input logic [1:0] grp,
		input logic [ISR_W-1:0] wd, output logic [ISR_W-1:0] rd);
		@(negedge clk_sys);
		host_req = 1'b1;
		host_op = op;
		host_grp = grp;
		host_wdata = wd;
		@(negedge clk_sys);
		host_req = 1'b0;
		host_op = ISR_OP_NOP;
		host_wdata = ~wd; // Released data never keeps its value
		@(negedge clk_sys) rd = host_rdata;
	endtask : cmd
endmodule : isr_host_model

//--- verif/isr_status_bank_tb.sv
// Self-checking bench of the instrument status bank
`timescale 1ns/1ps

module isr_status_bank_tb;
	import isr_pkg::*;
	typedef struct packed {logic [1:0] g; logic [15:0] s; logic [15:0] e;} isr_row_t;
	logic clk_sys, rst_b, meas_start, ovl_volt, ovl_curr, ovl_freq, ovl_cap;
	logic ovl_res, ovl_temp, cal_corrupt, lo_limit_fail, mem_overflow;
	logic cal_busy, selftest_busy, scan_busy, wait_trig, usb_drive;
	logic inst_locked, err_queue_ne, cfg_front_chg, cfg_remote_chg;
	logic alarm_qne, alarm_qovf, alarm_lo, alarm_up, host_req, host_ack;
	logic sum_mflt, sum_opst, sum_alrm;
	logic [3:0] alarm_event, alarm_active;
	logic [2:0] host_op;
	logic [1:0] host_grp;
	logic [15:0] rd_count, host_wdata, host_rdata, rd;
	int n_fail, cmp_count, cyc;
	// Stimulus per group, expected event word
	isr_row_t rows [15] = '{'{2'h0, 16'h0001, 16'h0001},
		'{2'h0, 16'h0002, 16'h0002}, '{2'h0, 16'h0020, 16'h0020},
		'{2'h0, 16'h0080, 16'h0080}, '{2'h0, 16'h0200, 16'h0200},
		'{2'h0, 16'h0400, 16'h0400}, '{2'h0, 16'h1900, 16'h1900},
		'{2'h0, 16'hFFFF, 16'h1FA3}, '{2'h1, 16'h24B3, 16'h24B3},
		'{2'h1, 16'h0800, 16'h0800}, '{2'h1, 16'hFFFF, 16'h2DB3},
		'{2'h2, 16'h000F, 16'h000F}, '{2'h2, 16'h3020, 16'h3020},
		'{2'h2, 16'h03D0, 16'h03D0}, '{2'h2, 16'hFFFF, 16'h33FF}};
	logic [15:0] impl [3] = '{MFLT_IMPL, OPST_IMPL, ALRM_IMPL};

	// ==========================================================
	// Design, host model and clock
	// ==========================================================
	isr_status_bank DUT (.clk_sys(clk_sys), .rst_b(rst_b),
		.meas_start(meas_start), .ovl_volt(ovl_volt), .ovl_curr(ovl_curr),
		.ovl_freq(ovl_freq), .ovl_cap(ovl_cap), .ovl_res(ovl_res),
		.ovl_temp(ovl_temp), .cal_corrupt(cal_corrupt),
		.lo_limit_fail(lo_limit_fail), .mem_overflow(mem_overflow),
		.cal_busy(cal_busy), .selftest_busy(selftest_busy),
		.scan_busy(scan_busy), .wait_trig(wait_trig), .usb_drive(usb_drive),
		.inst_locked(inst_locked), .err_queue_ne(err_queue_ne),
		.rd_count(rd_count), .cfg_front_chg(cfg_front_chg),
		.cfg_remote_chg(cfg_remote_chg), .alarm_event(alarm_event),
		.alarm_qne(alarm_qne), .alarm_qovf(alarm_qovf),
		.alarm_active(alarm_active), .alarm_lo(alarm_lo), .alarm_up(alarm_up),
		.host_req(host_req), .host_op(host_op), .host_grp(host_grp),
		.host_wdata(host_wdata), .host_ack(host_ack),
		.host_rdata(host_rdata), .sum_mflt(sum_mflt), .sum_opst(sum_opst),
		.sum_alrm(sum_alrm));
	isr_host_model HOST (.clk_sys(clk_sys), .host_rdata(host_rdata),
		.host_req(host_req), .host_op(host_op), .host_grp(host_grp),
		.host_wdata(host_wdata));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// ==========================================================
	// Helpers
	// ==========================================================
	task clr; // All engine inputs low, rd_count left as is
		{meas_start, ovl_volt, ovl_curr, ovl_freq, ovl_cap, ovl_res, ovl_temp,
			cal_corrupt, lo_limit_fail, mem_overflow, cal_busy, selftest_busy,
			scan_busy, wait_trig, usb_drive, inst_locked, err_queue_ne,
			cfg_front_chg, cfg_remote_chg, alarm_qne, alarm_qovf, alarm_lo,
			alarm_up, alarm_event, alarm_active} = '0;
	endtask : clr
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task start; // One measurement start pulse
		@(negedge clk_sys) meas_start = 1'b1;
		@(negedge clk_sys) meas_start = 1'b0;
	endtask : start
	task drive(input logic [1:0] g, input logic [15:0] b); // One-cycle stimulus
		@(negedge clk_sys);
		if (g == 2'h0) begin
			{ovl_volt, ovl_curr, ovl_freq, ovl_cap} = {b[0], b[1], b[5], b[7]};
			{mem_overflow, lo_limit_fail, ovl_temp, ovl_res, cal_corrupt} = b[12:8];
		end else if (g == 2'h1) begin
			{cal_busy, selftest_busy, scan_busy, wait_trig} = {b[0], b[1], b[4], b[5]};
			{usb_drive, cfg_front_chg, inst_locked} = {b[7], b[8], b[10]};
			{cfg_remote_chg, err_queue_ne} = {b[11], b[13]};
		end else begin
			{alarm_qovf, alarm_qne, alarm_event} = b[5:0];
			{alarm_active, alarm_lo, alarm_up} = {b[9:6], b[12], b[13]};
		end
		@(negedge clk_sys) clr();
	endtask : drive
	task complete_run;
		if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	// Hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			complete_run();
		end
	end

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		clr();
		rd_count = 16'h0000;
		rst_b = 1'b0;
		repeat (12) @(negedge clk_sys);
		rst_b = 1'b1;
		chk({13'h0, sum_alrm, sum_opst, sum_mflt}, 16'h0000);
		drive(2'h0, 16'h0001); // Overload before any start is dropped
		HOST.cmd(ISR_OP_RD_EVT, 2'h0, 16'h0000, rd); chk(rd, 16'h0000);
		foreach (rows[i]) begin
			start();
			drive(rows[i].g, rows[i].s);
			HOST.cmd(ISR_OP_RD_EVT, rows[i].g, 16'h0000, rd); chk(rd, rows[i].e);
			HOST.cmd(ISR_OP_RD_EVT, rows[i].g, 16'h0000, rd); chk(rd, 16'h0000);
		end
		// Repeated overloads, clear, re-arm
		start(); drive(2'h0, 16'h0001); drive(2'h0, 16'h0001);
		HOST.cmd(ISR_OP_RD_EVT, 2'h0, 16'h0000, rd); chk(rd, 16'h0001);
		drive(2'h0, 16'h0001);
		HOST.cmd(ISR_OP_RD_EVT, 2'h0, 16'h0000, rd); chk(rd, 16'h0000);
		start(); drive(2'h0, 16'h0001);
		HOST.cmd(ISR_OP_RD_EVT, 2'h0, 16'h0000, rd); chk(rd, 16'h0001);
		// Mask into summary, then clear status
		HOST.cmd(ISR_OP_WR_EN, 2'h0, 16'h0001, rd);
		start(); drive(2'h0, 16'h0002); repeat (3) @(negedge clk_sys);
		chk({15'h0, sum_mflt}, 16'h0000);
		drive(2'h0, 16'h0001); repeat (3) @(negedge clk_sys);
		chk({15'h0, sum_mflt}, 16'h0001);
		HOST.cmd(ISR_OP_CLS, 2'h3, 16'h0000, rd); repeat (3) @(negedge clk_sys);
		chk({15'h0, sum_mflt}, 16'h0000);
		for (int g = 0; g < 3; g++) begin
			HOST.cmd(ISR_OP_WR_EN, g[1:0], 16'hFFFF, rd);
			HOST.cmd(ISR_OP_RD_EN, g[1:0], 16'h0000, rd); chk(rd, impl[g]);
			HOST.cmd(ISR_OP_WR_EN, g[1:0], 16'h0000, rd);
		end
		// Reading count threshold, strict compare
		HOST.cmd(ISR_OP_WR_THR, 2'h3, 16'h0005, rd);
		HOST.cmd(ISR_OP_RD_THR, 2'h3, 16'h0000, rd); chk(rd, 16'h0005);
		rd_count = 16'h0005;
		HOST.cmd(ISR_OP_RD_COND, 2'h1, 16'h0000, rd); chk(rd & 16'h0200, 16'h0000);
		rd_count = 16'h0006;
		HOST.cmd(ISR_OP_RD_COND, 2'h1, 16'h0000, rd); chk(rd & 16'h0200, 16'h0200);
		// Front panel change flag, cleared by start
		drive(2'h1, 16'h0100);
		HOST.cmd(ISR_OP_RD_COND, 2'h1, 16'h0000, rd); chk(rd & 16'h0900, 16'h0100);
		start();
		HOST.cmd(ISR_OP_RD_COND, 2'h1, 16'h0000, rd); chk(rd & 16'h0100, 16'h0000);
		// Live lock level, unused group
		inst_locked = 1'b1;
		HOST.cmd(ISR_OP_RD_COND, 2'h1, 16'h0000, rd); chk(rd & 16'h0400, 16'h0400);
		inst_locked = 1'b0;
		HOST.cmd(ISR_OP_RD_EVT, 2'h3, 16'h0000, rd); chk(rd, 16'h0000);
		complete_run();
	end
endmodule : isr_status_bank_tb
